// ### rtl/fgp_defines.svh
// fgp_defines.svh - offsets, field positions, reset values of the port
// assumes: included by its bare name from the sampler, pad decode and top level design files of the port
`ifndef FGP_DEFINES_SVH
`define FGP_DEFINES_SVH

// -----------------------------------------------------------------------
// register byte addresses on the special function register bus
// -----------------------------------------------------------------------
`define FGP_ADDR_DATA 16'hf26e
`define FGP_ADDR_DIR 16'hf26f
`define FGP_ADDR_CFG0 16'hf270
`define FGP_ADDR_CFG1 16'hf271
`define FGP_ADDR_MOD0 16'hf272
`define FGP_ADDR_MOD1 16'hf273

// -----------------------------------------------------------------------
// field layout and reset values
// -----------------------------------------------------------------------
`define FGP_PIN_COUNT 5
`define FGP_PIN_MSB 4
`define FGP_REG_RESET 5'h00
`define FGP_BYTE_ZERO 8'h00
`define FGP_UPPER_ZERO 3'h0

// per pin, four bits: bit k set when function code k is a legal code
// pin 4 holds bits 19:16, pin 0 holds bits 3:0
`define FGP_MODE_LEGAL 20'h5f755

`endif

// ### rtl/fgp_pkg.sv
// fgp_pkg.sv - types shared by the port modules
// assumes: nothing beyond a SystemVerilog compiler
package fgp_pkg;

    // output drive type selected by {plane1, plane0} in output mode
    typedef enum logic [1:0] {
        FGP_DRV_HIZ,
        FGP_DRV_PCH,
        FGP_DRV_NCH,
        FGP_DRV_CMOS
    } fgp_drive_t;

    // input termination selected by {plane1, plane0} in input mode
    typedef enum logic [1:0] {
        FGP_TRM_HIZ,
        FGP_TRM_PULL_DOWN,
        FGP_TRM_PULL_UP,
        FGP_TRM_HIZ_ALT
    } fgp_term_t;

endpackage

// ### rtl/fgp_pin_if.sv
// fgp_pin_if.sv - register state carried from the port core to the pads
// assumes: one driver (ctl) and one reader (pad) on the same clock
interface fgp_pin_if;
    logic [4:0] dir;
    logic [4:0] data;
    logic [4:0] cfg0;
    logic [4:0] cfg1;
    logic [4:0] mode0;
    logic [4:0] mode1;
    logic [4:0] alt_data;

    modport ctl (output dir, data, cfg0, cfg1, mode0, mode1, alt_data);
    modport pad (input dir, data, cfg0, cfg1, mode0, mode1, alt_data);
endinterface

// ### rtl/fgp_in_sync.sv
// fgp_in_sync.sv - three-stage sampler for the asynchronous pin levels
// assumes: pins change freely against ref_clk
`include "fgp_defines.svh"

module fgp_in_sync #(
    parameter int WIDTH = 5
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level
);

    // -------------------------------------------------------------------
    // sampling chain
    // -------------------------------------------------------------------
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] level_r;
    logic [WIDTH-1:0] agree;
    logic [WIDTH-1:0] level_nxt;

    // a bit follows only once stages two and three agree
    assign agree = ~(s2_r ^ s3_r);
    assign level_nxt = (agree & s3_r) | (~agree & level_r);
    assign level = level_r;

    // chain and filtered level
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            level_r <= '0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            level_r <= level_nxt;
        end
    end

endmodule

// ### rtl/fgp_pad_ctl.sv
// fgp_pad_ctl.sv - per pin drive, enable and termination decode
// assumes: register state arrives over fgp_pin_if on ref_clk
`include "fgp_defines.svh"

module fgp_pad_ctl (
    input wire logic ref_clk,
    input wire logic rst_b,
    fgp_pin_if.pad cfg,
    output logic [4:0] pin_out,
    output logic [4:0] pin_oe,
    output logic [4:0] pull_up_en,
    output logic [4:0] pull_down_en
);

    localparam logic [19:0] LEGAL = `FGP_MODE_LEGAL;

    // -------------------------------------------------------------------
    // combinational decode, one slice per pin
    // -------------------------------------------------------------------
    logic [4:0] out_nxt;
    logic [4:0] oe_nxt;
    logic [4:0] pu_nxt;
    logic [4:0] pd_nxt;

    genvar g;
    generate
        for (g = 0; g < `FGP_PIN_COUNT; g = g + 1) begin : g_pin
            wire logic [1:0] code = {cfg.mode1[g], cfg.mode0[g]};
            wire logic gp = (code == 2'h0);
            wire logic legal = LEGAL[4*g + code];
            wire logic is_in = cfg.dir[g];
            wire fgp_pkg::fgp_drive_t drv =
                fgp_pkg::fgp_drive_t'({cfg.cfg1[g], cfg.cfg0[g]});
            wire fgp_pkg::fgp_term_t trm =
                fgp_pkg::fgp_term_t'({cfg.cfg1[g], cfg.cfg0[g]});
            // reserved code forces the value low, data is ignored
            wire logic val = gp ? cfg.data[g]
                : (legal ? cfg.alt_data[g] : 1'b0);
            // drive type follows the direction bit at once
            assign out_nxt[g] = (drv == fgp_pkg::FGP_DRV_PCH) ? 1'b1
                : ((drv == fgp_pkg::FGP_DRV_NCH) ? 1'b0 : val);
            assign oe_nxt[g] = !is_in && (
                (drv == fgp_pkg::FGP_DRV_CMOS) ||
                (drv == fgp_pkg::FGP_DRV_PCH && val) ||
                (drv == fgp_pkg::FGP_DRV_NCH && !val));
            assign pu_nxt[g] = is_in && (trm == fgp_pkg::FGP_TRM_PULL_UP);
            assign pd_nxt[g] = is_in &&
                (trm == fgp_pkg::FGP_TRM_PULL_DOWN);
        end
    endgenerate

    // pad controls come from flip-flops, one cycle after the registers
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_out <= '0;
            pin_oe <= '0;
            pull_up_en <= '0;
            pull_down_en <= '0;
        end else begin
            pin_out <= out_nxt;
            pin_oe <= oe_nxt;
            pull_up_en <= pu_nxt;
            pull_down_en <= pd_nxt;
        end
    end

endmodule

// ### rtl/fgp_port.sv
// fgp_port.sv - five pin general purpose port, top level
// assumes: special function register bus on ref_clk, pins asynchronous,
// pad cells combine pin_out, pin_oe and the pull enables
//
// Operation
// - output pins drive the data register level
// - input pins read back sampled pin level
// - written bits 4-0 read back unchanged, except data bits of input pins
// - direction 0 output, 1 input, reset output
// - output codes: hiz, p-open, n-open, cmos
// - input codes: hiz, pull-down, pull-up, hiz
// - all registers reset to zero
// - six registers at consecutive byte addresses
// - plane0 and mode0 also take word access
// - pin n maps to bit n, bits 4-0
// - control meaning follows current direction
// - mode code zero gives plain port pin
// - reserved code ignores data, drives low
`include "fgp_defines.svh"

module fgp_port (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [15:0] sfr_addr,
    input wire logic sfr_wr_en,
    input wire logic sfr_rd_en,
    input wire logic sfr_word,
    input wire logic [15:0] sfr_wdata,
    output logic [15:0] sfr_rdata,
    input wire logic [4:0] alt_out_data,
    output logic [4:0] pin_level,
    input wire logic [4:0] pin_in,
    output logic [4:0] pin_out,
    output logic [4:0] pin_oe,
    output logic [4:0] pull_up_en,
    output logic [4:0] pull_down_en
);

    // -------------------------------------------------------------------
    // registers
    // -------------------------------------------------------------------
    logic [4:0] port_data_r;
    logic [4:0] port_direction_r;
    logic [4:0] pin_config_plane0_r;
    logic [4:0] pin_config_plane1_r;
    logic [4:0] alt_function_sel0_r;
    logic [4:0] alt_function_sel1_r;
    logic [15:0] sfr_rdata_r;
    logic [15:0] sfr_rdata_nxt;
    logic [4:0] level;

    // true when the access targets byte register at base
    function automatic logic byte_hit(input logic [15:0] addr,
                                      input logic word,
                                      input logic [15:0] base);
        byte_hit = !word && (addr == base);
    endfunction

    // true when a word access pairs base with the next byte
    function automatic logic word_hit(input logic [15:0] addr,
                                      input logic word,
                                      input logic [15:0] base);
        word_hit = word && (addr == base);
    endfunction

    // -------------------------------------------------------------------
    // address decode
    // -------------------------------------------------------------------
    wire logic hit_data = byte_hit(sfr_addr, sfr_word, `FGP_ADDR_DATA);
    wire logic hit_dir = byte_hit(sfr_addr, sfr_word, `FGP_ADDR_DIR);
    wire logic hit_c0 = byte_hit(sfr_addr, sfr_word, `FGP_ADDR_CFG0);
    wire logic hit_c1 = byte_hit(sfr_addr, sfr_word, `FGP_ADDR_CFG1);
    wire logic hit_m0 = byte_hit(sfr_addr, sfr_word, `FGP_ADDR_MOD0);
    wire logic hit_m1 = byte_hit(sfr_addr, sfr_word, `FGP_ADDR_MOD1);
    wire logic hit_cw = word_hit(sfr_addr, sfr_word, `FGP_ADDR_CFG0);
    wire logic hit_mw = word_hit(sfr_addr, sfr_word, `FGP_ADDR_MOD0);

    // write strobes; word access writes the low and the next byte
    wire logic wr_data = sfr_wr_en && hit_data;
    wire logic wr_dir = sfr_wr_en && hit_dir;
    wire logic wr_c0 = sfr_wr_en && (hit_c0 || hit_cw);
    wire logic wr_c1 = sfr_wr_en && (hit_c1 || hit_cw);
    wire logic wr_m0 = sfr_wr_en && (hit_m0 || hit_mw);
    wire logic wr_m1 = sfr_wr_en && (hit_m1 || hit_mw);

    // the high byte of a word lands in the next register
    wire logic [4:0] wr_lo = sfr_wdata[4:0];
    wire logic [4:0] wr_c1_val = hit_cw ? sfr_wdata[12:8] : wr_lo;
    wire logic [4:0] wr_m1_val = hit_mw ? sfr_wdata[12:8] : wr_lo;

    // -------------------------------------------------------------------
    // read path
    // -------------------------------------------------------------------
    // input pins show the sampled level, outputs show the stored bit
    wire logic [4:0] data_view = (port_direction_r & level) |
        (~port_direction_r & port_data_r);

    // read mux, upper bits zero, unmapped or illegal word reads zero
    always_comb begin
        sfr_rdata_nxt = '0;
        if (hit_data) begin
            sfr_rdata_nxt = {`FGP_BYTE_ZERO, `FGP_UPPER_ZERO, data_view};
        end else if (hit_dir) begin
            sfr_rdata_nxt = {`FGP_BYTE_ZERO, `FGP_UPPER_ZERO,
                port_direction_r};
        end else if (hit_c0) begin
            sfr_rdata_nxt = {`FGP_BYTE_ZERO, `FGP_UPPER_ZERO,
                pin_config_plane0_r};
        end else if (hit_c1) begin
            sfr_rdata_nxt = {`FGP_BYTE_ZERO, `FGP_UPPER_ZERO,
                pin_config_plane1_r};
        end else if (hit_m0) begin
            sfr_rdata_nxt = {`FGP_BYTE_ZERO, `FGP_UPPER_ZERO,
                alt_function_sel0_r};
        end else if (hit_m1) begin
            sfr_rdata_nxt = {`FGP_BYTE_ZERO, `FGP_UPPER_ZERO,
                alt_function_sel1_r};
        end else if (hit_cw) begin
            sfr_rdata_nxt = {`FGP_UPPER_ZERO, pin_config_plane1_r,
                `FGP_UPPER_ZERO, pin_config_plane0_r};
        end else if (hit_mw) begin
            sfr_rdata_nxt = {`FGP_UPPER_ZERO, alt_function_sel1_r,
                `FGP_UPPER_ZERO, alt_function_sel0_r};
        end
    end

    assign sfr_rdata = sfr_rdata_r;
    assign pin_level = level;

    // -------------------------------------------------------------------
    // register storage
    // -------------------------------------------------------------------
    // data and direction, byte access only
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            port_data_r <= `FGP_REG_RESET;
            port_direction_r <= `FGP_REG_RESET;
        end else begin
            if (wr_data) begin
                port_data_r <= wr_lo;
            end
            if (wr_dir) begin
                port_direction_r <= wr_lo;
            end
        end
    end

    // control planes
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_config_plane0_r <= `FGP_REG_RESET;
            pin_config_plane1_r <= `FGP_REG_RESET;
        end else begin
            if (wr_c0) begin
                pin_config_plane0_r <= wr_lo;
            end
            if (wr_c1) begin
                pin_config_plane1_r <= wr_c1_val;
            end
        end
    end

    // function select planes
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            alt_function_sel0_r <= `FGP_REG_RESET;
            alt_function_sel1_r <= `FGP_REG_RESET;
        end else begin
            if (wr_m0) begin
                alt_function_sel0_r <= wr_lo;
            end
            if (wr_m1) begin
                alt_function_sel1_r <= wr_m1_val;
            end
        end
    end

    // read data held until the next read
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sfr_rdata_r <= '0;
        end else if (sfr_rd_en) begin
            sfr_rdata_r <= sfr_rdata_nxt;
        end
    end

    // -------------------------------------------------------------------
    // pads and sampling
    // -------------------------------------------------------------------
    fgp_pin_if pin_bus ();

    // register state toward the pad decode
    assign pin_bus.dir = port_direction_r;
    assign pin_bus.data = port_data_r;
    assign pin_bus.cfg0 = pin_config_plane0_r;
    assign pin_bus.cfg1 = pin_config_plane1_r;
    assign pin_bus.mode0 = alt_function_sel0_r;
    assign pin_bus.mode1 = alt_function_sel1_r;
    assign pin_bus.alt_data = alt_out_data;

    fgp_pad_ctl u_pad (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .cfg(pin_bus.pad),
        .pin_out(pin_out),
        .pin_oe(pin_oe),
        .pull_up_en(pull_up_en),
        .pull_down_en(pull_down_en)
    );

    fgp_in_sync #(
        .WIDTH(`FGP_PIN_COUNT)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .pin_in(pin_in),
        .level(level)
    );

endmodule

// ### sim/fgp_board.sv
// fgp_board.sv - board circuitry on the five port pins
// assumes: the device drive wins, then the board driver, then the pulls
module fgp_board (
    input wire logic ref_clk,
    input wire logic [4:0] pin_out,
    input wire logic [4:0] pin_oe,
    input wire logic [4:0] pull_up_en,
    input wire logic [4:0] pull_down_en,
    input wire logic [4:0] ext_val,
    input wire logic [4:0] ext_en,
    output logic [4:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] float_r = 5'h0a;

    // a pin that nobody holds wanders every cycle
    always_ff @(posedge ref_clk) begin
        float_r <= ~float_r;
    end

    // wire level of each pin
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & (pull_up_en | (~pull_down_en & float_r)));
endmodule

// ### sim/fgp_port_chk.sv
// fgp_port_chk.sv - port assertions, register state shadowed from writes
// assumes: bound to fgp_port, single clock domain
`include "fgp_defines.svh"

module fgp_port_chk (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [15:0] sfr_addr,
    input wire logic sfr_wr_en,
    input wire logic sfr_rd_en,
    input wire logic sfr_word,
    input wire logic [15:0] sfr_wdata,
    input wire logic [15:0] sfr_rdata,
    input wire logic [4:0] alt_out_data,
    input wire logic [4:0] pin_level,
    input wire logic [4:0] pin_in,
    input wire logic [4:0] pin_out,
    input wire logic [4:0] pin_oe,
    input wire logic [4:0] pull_up_en,
    input wire logic [4:0] pull_down_en
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] dat_r, dir_r, c0_r, c1_r, m0_r, m1_r, gp, v, e_oe, rdd;
    logic [15:0] e_rd;

    // legal function codes per pin
    function automatic logic [4:0] legal(input logic [4:0] m0, m1);
        logic [19:0] tbl;
        tbl = `FGP_MODE_LEGAL;
        for (int i = 0; i < 5; i++) begin
            legal[i] = tbl[4 * i + {m1[i], m0[i]}];
        end
    endfunction

    // shadow registers
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            {dat_r, dir_r, c0_r, c1_r, m0_r, m1_r} <= '0;
        end else if (sfr_wr_en && !sfr_word) begin
            case (sfr_addr)
                `FGP_ADDR_DATA: dat_r <= sfr_wdata[4:0];
                `FGP_ADDR_DIR: dir_r <= sfr_wdata[4:0];
                `FGP_ADDR_CFG0: c0_r <= sfr_wdata[4:0];
                `FGP_ADDR_CFG1: c1_r <= sfr_wdata[4:0];
                `FGP_ADDR_MOD0: m0_r <= sfr_wdata[4:0];
                `FGP_ADDR_MOD1: m1_r <= sfr_wdata[4:0];
                default: ;
            endcase
        end else if (sfr_wr_en && sfr_addr == `FGP_ADDR_CFG0) begin
            {c1_r, c0_r} <= {sfr_wdata[12:8], sfr_wdata[4:0]};
        end else if (sfr_wr_en && sfr_addr == `FGP_ADDR_MOD0) begin
            {m1_r, m0_r} <= {sfr_wdata[12:8], sfr_wdata[4:0]};
        end
    end

    // expected drive value, enable and read data
    assign gp = ~(m0_r | m1_r);
    assign v = (gp & dat_r) | (~gp & legal(m0_r, m1_r) & alt_out_data);
    assign e_oe = ~dir_r & ((c1_r & c0_r) | (~c1_r & c0_r & v)
        | (c1_r & ~c0_r & ~v));
    assign rdd = (dat_r & ~dir_r) | (pin_level & dir_r);
    assign e_rd = sfr_word ? (sfr_addr == `FGP_ADDR_CFG0 ? {3'h0, c1_r,
        3'h0, c0_r} : sfr_addr == `FGP_ADDR_MOD0 ? {3'h0, m1_r, 3'h0, m0_r}
        : 16'h0000) : {11'h000, sfr_addr == `FGP_ADDR_DATA ? rdd
        : sfr_addr == `FGP_ADDR_DIR ? dir_r : sfr_addr == `FGP_ADDR_CFG0
        ? c0_r : sfr_addr == `FGP_ADDR_CFG1 ? c1_r : sfr_addr ==
        `FGP_ADDR_MOD0 ? m0_r : sfr_addr == `FGP_ADDR_MOD1 ? m1_r : 5'h00};

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    oe_decode_a: assert property (pin_oe == $past(e_oe))
        else $error("pad enable differs from decode");
    out_level_a: assert property (
        (pin_out & pin_oe) == $past(v & e_oe))
        else $error("driven level differs from value");
    pull_up_a: assert property (
        pull_up_en == $past(dir_r & c1_r & ~c0_r))
        else $error("pull-up enable wrong");
    pull_down_a: assert property (
        pull_down_en == $past(dir_r & ~c1_r & c0_r))
        else $error("pull-down enable wrong");
    read_back_a: assert property (
        sfr_rd_en |=> sfr_rdata == $past(e_rd))
        else $error("read data wrong");
    upper_zero_a: assert property (
        sfr_rd_en ##1 1'b1 |-> !(|(sfr_rdata & 16'he0e0)))
        else $error("unused read bits not zero");
    reset_idle_a: assert property (
        $rose(rst_b) |-> !(|{pin_oe, pull_up_en, pull_down_en}))
        else $error("pins not idle after reset");
    no_drive_pull_a: assert property (
        !(|(pin_oe & (pull_up_en | pull_down_en))))
        else $error("pull on a driven pin");
    rd_hold_a: assert property (!sfr_rd_en |=> $stable(sfr_rdata))
        else $error("read data moved without read");

    cover property (sfr_wr_en && sfr_word);
    cover property (sfr_rd_en && sfr_addr == `FGP_ADDR_DATA && |dir_r);
    cover property (|(~gp & ~legal(m0_r, m1_r) & ~dir_r));
endmodule

bind fgp_port fgp_port_chk i_fgp_port_chk (.ref_clk, .rst_b, .sfr_addr,
    .sfr_wr_en, .sfr_rd_en, .sfr_word, .sfr_wdata, .sfr_rdata, .alt_out_data,
    .pin_level, .pin_in, .pin_out, .pin_oe, .pull_up_en, .pull_down_en);

// ### sim/fgp_port_test.sv
// fgp_port_test.sv - register and pin tests of the five pin port
// assumes: fgp_port, fgp_board and the checker bind compiled before it
`include "fgp_defines.svh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
    error_cnt++; $display("Error %s expected %h seen %h", nm, ex, got); end end

module fgp_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] a_dat = `FGP_ADDR_DATA;
    localparam logic [15:0] a_dir = `FGP_ADDR_DIR;
    localparam logic [15:0] a_cf0 = `FGP_ADDR_CFG0;
    localparam logic [15:0] a_md0 = `FGP_ADDR_MOD0;
    logic ref_clk, rst_b, sfr_wr_en, sfr_rd_en, sfr_word;
    logic [15:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic [4:0] alt_out_data, pin_level, pin_in, pin_out, pin_oe;
    logic [4:0] pull_up_en, pull_down_en, ext_val, ext_en;
    logic [4:0] oe_tab [4] = '{5'h00, 5'h15, 5'h0a, 5'h1f};
    int error_cnt = 0;
    int n_checks = 0;

    fgp_port i_fgp_port (.ref_clk, .rst_b, .sfr_addr, .sfr_wr_en, .sfr_rd_en,
        .sfr_word, .sfr_wdata, .sfr_rdata, .alt_out_data, .pin_level, .pin_in,
        .pin_out, .pin_oe, .pull_up_en, .pull_down_en);
    fgp_board i_fgp_board (.ref_clk, .pin_out, .pin_oe, .pull_up_en,
        .pull_down_en, .ext_val, .ext_en, .pin_in);

    // -------------------------------------------------------------------
    // bus tasks
    // -------------------------------------------------------------------
    task automatic wr(input logic [15:0] a, input logic w,
        input logic [15:0] d);
        @(posedge ref_clk);
        sfr_addr <= a;
        sfr_word <= w;
        sfr_wdata <= d;
        sfr_wr_en <= 1'b1;
        @(posedge ref_clk);
        sfr_wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic w,
        input logic [15:0] e);
        @(posedge ref_clk);
        sfr_addr <= a;
        sfr_word <= w;
        sfr_rd_en <= 1'b1;
        @(posedge ref_clk);
        sfr_rd_en <= 1'b0;
        #1 `CHK("sfr_rdata", e, sfr_rdata)
    endtask

    // pad state two edges after the write
    task automatic pins(input logic [4:0] oe, input logic [4:0] val);
        repeat (2) @(posedge ref_clk);
        #1 `CHK("pin_oe", oe, pin_oe)
        `CHK("pin_out", val & oe, pin_out & pin_oe)
    endtask

    task automatic end_sim;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (4000) @(posedge ref_clk);
        error_cnt++;
        end_sim();
    end

    initial begin
        {rst_b, sfr_wr_en, sfr_rd_en, sfr_word} = 4'h0;
        {sfr_addr, sfr_wdata} = 32'h0;
        {alt_out_data, ext_val, ext_en} = 15'h0;
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        pins(5'h00, 5'h00);
        for (int i = 0; i < 6; i++) begin
            rd(a_dat + 16'(i), 1'b0, 16'h0000);
            wr(a_dat + 16'(i), 1'b0, 16'hffff);
            rd(a_dat + 16'(i), 1'b0, 16'h001f);
        end
        for (int i = 0; i < 6; i++) begin
            wr(a_dat + 16'(i), 1'b0, 16'h0000);
        end
        wr(a_cf0, 1'b1, 16'hffff);
        rd(a_cf0, 1'b1, 16'h1f1f);
        wr(a_md0, 1'b1, 16'h0a15);
        rd(a_md0 + 16'h1, 1'b0, 16'h000a);
        wr(a_dir, 1'b1, 16'h1f1f);
        rd(a_dir, 1'b0, 16'h0000);
        rd(a_dat, 1'b1, 16'h0000);
        wr(16'hf274, 1'b0, 16'h00ff);
        rd(16'hf274, 1'b0, 16'h0000);
        wr(a_md0, 1'b1, 16'h0000);
        wr(a_dat, 1'b0, 16'h0015);
        for (int k = 0; k < 4; k++) begin
            wr(a_cf0, 1'b1, {3'h0, {5{k[1]}}, 3'h0, {5{k[0]}}});
            pins(oe_tab[k], 5'h15);
        end
        rd(a_dat, 1'b0, 16'h0015);
        @(posedge ref_clk);
        ext_val <= 5'h0a;
        ext_en <= 5'h1f;
        wr(a_dir, 1'b0, 16'h001f);
        pins(5'h00, 5'h00);
        repeat (6) @(posedge ref_clk);
        rd(a_dat, 1'b0, 16'h000a);
        `CHK("pin_level", 5'h0a, pin_level)
        ext_en <= 5'h00;
        for (int k = 0; k < 4; k++) begin
            wr(a_cf0, 1'b1, {3'h0, {5{k[1]}}, 3'h0, {5{k[0]}}});
            repeat (8) @(posedge ref_clk);
            #1 `CHK("pull_up_en", k == 2 ? 5'h1f : 5'h00, pull_up_en)
            `CHK("pull_down_en", k == 1 ? 5'h1f : 5'h00, pull_down_en)
            if (k == 1 || k == 2) begin
                rd(a_dat, 1'b0, k == 2 ? 16'h001f : 16'h0000);
            end
        end
        wr(a_cf0, 1'b1, 16'h1f00);
        wr(a_dir, 1'b0, 16'h0000);
        pins(5'h0a, 5'h15);
        @(posedge ref_clk);
        alt_out_data <= 5'h1d;
        wr(a_cf0, 1'b1, 16'h1f1f);
        wr(a_md0, 1'b1, 16'h1f00);
        pins(5'h1f, 5'h1d);
        wr(a_md0, 1'b1, 16'h001f);
        pins(5'h1f, 5'h0c);
        wr(a_cf0, 1'b1, 16'h001f);
        pins(5'h0c, 5'h0c);
        wr(a_md0, 1'b1, 16'h0000);
        pins(5'h15, 5'h15);
        // reset in mid-run clears every register and idles the pins
        @(posedge ref_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        pins(5'h00, 5'h00);
        rd(a_dat, 1'b0, 16'h0000);
        rd(a_cf0, 1'b1, 16'h0000);
        rd(a_md0, 1'b1, 16'h0000);
        end_sim();
    end
endmodule
